// [hw/fdc_cmd_pkg.sv]
// Functional notes
// R1 - Eleven commands in four types
// R2 - Host writes only when not busy
// R3 - Forced interrupt accepted while busy
// R4 - Busy held while a command runs
// R5 - Completion clears busy, raises interrupt
// R6 - Status shows error or clean end
// R7 - Type I opcodes from bits 7..4
// R8 - Type II, III, IV opcodes
// R9 - Bits 1..0 pick step rate
// R10 - Bit 2 requests track verify
// R11 - Bit 3 loads or unloads head
// R12 - Bit 4 enables track update
// R13 - Bit 0 picks FB or F8 mark
// R14 - Side compare enable and side
// R15 - Bit 1 drives side select output
// R16 - Bit 3 is sector length flag
// R17 - Bit 2 adds 15 ms settle delay
// R18 - Bit 4 selects multiple records
// R19 - Ready edges and index raise interrupt
// R20 - Immediate interrupt stays until reset; the code also clears it on a new forced interrupt
// R21 - All-zero conditions: terminate, no interrupt
// R22 - Status read or command write clears
// R23 - Not ready: reject and interrupt; the code rejects only type II/III, type I still starts
// R24 - Rate codes give 3/6/10/15 ms
// R25 - Commands while busy are ignored
// R26 - Command fields held during execution
`default_nettype none
package fdc_cmd_pkg;
  // ----------------------------------------
  // Host register map and status layout
  // ----------------------------------------
  localparam logic [1:0] CMD_STATUS_ADDR = 2'h0;
  localparam int BUSY_BIT = 0;
  localparam int NOT_READY_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // ----------------------------------------
  // Command word field positions
  // ----------------------------------------
  localparam int RATE_LSB = 0;
  localparam int MARK_BIT = 0;
  localparam int SIDE_BIT = 1;
  localparam int VERIFY_BIT = 2;
  localparam int DELAY_BIT = 2;
  localparam int HEAD_BIT = 3;
  localparam int SIDE_NUM_BIT = 3;
  localparam int UPDATE_BIT = 4;
  localparam int MULTI_BIT = 4;
  localparam int IMMED_BIT = 3;
  localparam logic [7:0] MARK_NORMAL = 8'hFB;
  localparam logic [7:0] MARK_DELETED = 8'hF8;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ = 50000;
  localparam int STEP0_MS = 3;
  localparam int STEP1_MS = 6;
  localparam int STEP2_MS = 10;
  localparam int STEP3_MS = 15;
  localparam int SETTLE_MS = 15;
  localparam int STEP0_CYC = STEP0_MS * CLK_KHZ;
  localparam int STEP1_CYC = STEP1_MS * CLK_KHZ;
  localparam int STEP2_CYC = STEP2_MS * CLK_KHZ;
  localparam int STEP3_CYC = STEP3_MS * CLK_KHZ;
  localparam int SETTLE_CYC = SETTLE_MS * CLK_KHZ;
  localparam int CNT_W = 24;
  // ----------------------------------------
  // Commands and types, one-hot
  // ----------------------------------------
  typedef enum logic [10:0] {
    CMD_NONE = 11'h000, CMD_RESTORE = 11'h001, CMD_SEEK = 11'h002,
    CMD_STEP = 11'h004, CMD_STEP_IN = 11'h008, CMD_STEP_OUT = 11'h010,
    CMD_RD_SEC = 11'h020, CMD_WR_SEC = 11'h040, CMD_RD_ADDR = 11'h080,
    CMD_RD_TRK = 11'h100, CMD_WR_TRK = 11'h200, CMD_FORCE = 11'h400
  } cmd_type;
  typedef enum logic [3:0] {
    TYPE_I = 4'h1, TYPE_II = 4'h2, TYPE_III = 4'h4, TYPE_IV = 4'h8
  } class_type;
endpackage
`default_nettype wire

// [hw/cmd_fields_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Raw command word and its decoded class
interface cmd_fields_if;
  logic [7:0] word;
  fdc_cmd_pkg::cmd_type cmd;
  fdc_cmd_pkg::class_type ctype;
  // Classifier turns the word into a command
  modport classifier (input word, output cmd, output ctype);
  // Top supplies the word and reads the result
  modport owner (output word, input cmd, input ctype);
endinterface
`default_nettype wire

// [hw/cmd_classifier.sv]
`timescale 1ns/1ps
`default_nettype none
module cmd_classifier (
  // Word in, command out
  cmd_fields_if.classifier fields
);
  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  // Pure decode; the top registers the result
  always_comb begin
    fields.cmd = fdc_cmd_pkg::CMD_NONE;
    fields.ctype = fdc_cmd_pkg::TYPE_I;
    case (fields.word[7:4])
      // Type I group R7
      4'h0: fields.cmd = fdc_cmd_pkg::CMD_RESTORE;
      4'h1: fields.cmd = fdc_cmd_pkg::CMD_SEEK;
      4'h2, 4'h3: fields.cmd = fdc_cmd_pkg::CMD_STEP;
      4'h4, 4'h5: fields.cmd = fdc_cmd_pkg::CMD_STEP_IN;
      4'h6, 4'h7: fields.cmd = fdc_cmd_pkg::CMD_STEP_OUT;
      // Type II group R8
      4'h8, 4'h9: begin
        fields.cmd = fdc_cmd_pkg::CMD_RD_SEC;
        fields.ctype = fdc_cmd_pkg::TYPE_II;
      end
      4'hA, 4'hB: begin
        fields.cmd = fdc_cmd_pkg::CMD_WR_SEC;
        fields.ctype = fdc_cmd_pkg::TYPE_II;
      end
      // Type III group R8
      4'hC: begin
        fields.cmd = fdc_cmd_pkg::CMD_RD_ADDR;
        fields.ctype = fdc_cmd_pkg::TYPE_III;
      end
      4'hE: begin
        fields.cmd = fdc_cmd_pkg::CMD_RD_TRK;
        fields.ctype = fdc_cmd_pkg::TYPE_III;
      end
      4'hF: begin
        fields.cmd = fdc_cmd_pkg::CMD_WR_TRK;
        fields.ctype = fdc_cmd_pkg::TYPE_III;
      end
      // Type IV, eleven commands in all R1
      4'hD: begin
        fields.cmd = fdc_cmd_pkg::CMD_FORCE;
        fields.ctype = fdc_cmd_pkg::TYPE_IV;
      end
      default: fields.cmd = fdc_cmd_pkg::CMD_NONE;
    endcase
  end
endmodule
`default_nettype wire

// [hw/floppy_command_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module floppy_command_decoder #(
  parameter int STEP0_CYCLES = fdc_cmd_pkg::STEP0_CYC,
  parameter int STEP1_CYCLES = fdc_cmd_pkg::STEP1_CYC,
  parameter int STEP2_CYCLES = fdc_cmd_pkg::STEP2_CYC,
  parameter int STEP3_CYCLES = fdc_cmd_pkg::STEP3_CYC,
  parameter int SETTLE_CYCLES = fdc_cmd_pkg::SETTLE_CYC,
  parameter bit SIDE_OUTPUT_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Host register port
  input wire logic cs_n_in,
  input wire logic we_n_in,
  input wire logic re_n_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  // Drive pins
  input wire logic drive_ready_in,
  input wire logic index_in,
  output logic side_select_output_out,
  output logic completion_irq_out,
  // Execution engine handshake
  input wire logic cmd_done_in,
  input wire logic [5:0] err_flags_in,
  output logic start_out,
  output logic abort_out,
  output logic busy_out,
  // Held command fields
  output logic [10:0] cmd_out,
  output logic [1:0] step_rate_select_out,
  output logic [fdc_cmd_pkg::CNT_W-1:0] step_cycles_out,
  output logic [fdc_cmd_pkg::CNT_W-1:0] settle_cycles_out,
  output logic verify_out,
  output logic head_load_out,
  output logic track_update_out,
  output logic [7:0] data_mark_out,
  output logic side_compare_en_out,
  output logic expected_side_out,
  output logic sector_len_flag_out,
  output logic multi_record_out
);
  localparam int CW = fdc_cmd_pkg::CNT_W;
  localparam int SW = 15;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_q; // Release shifter
  logic rst_n; // Synchronised reset
  // Asserts at once, releases after two edges
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [SW-1:0] pins; // Raw pin bundle
  logic [SW-1:0] s1_q; // First stage, read only by s2
  logic [SW-1:0] s2_q; // Usable copy
  assign pins = {cs_n_in, we_n_in, re_n_in, addr_in, data_in,
                 drive_ready_in, index_in};
  // One stage pair per pin bit
  genvar g;
  generate
    for (g = 0; g < SW; g++) begin : g_sync
      always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[g] <= 1'b1;
          s2_q[g] <= 1'b1;
        end else begin
          s1_q[g] <= pins[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate
  logic cs_n, we_n, re_n, rdy, idx;
  logic [1:0] addr;
  logic [7:0] wdata;
  assign {cs_n, we_n, re_n, addr, wdata, rdy, idx} = s2_q;

  // ----------------------------------------
  // Strobe edges
  // ----------------------------------------
  logic wr_act, rd_act; // Strobe windows at address 0
  logic wr_prev_q, rd_prev_q, rdy_prev_q, idx_prev_q;
  logic [7:0] hold_q; // Word seen during the write strobe
  logic take, rd_rise, idx_rise;
  assign wr_act = !cs_n && !we_n && addr == fdc_cmd_pkg::CMD_STATUS_ADDR;
  assign rd_act = !cs_n && !re_n && addr == fdc_cmd_pkg::CMD_STATUS_ADDR;
  // Word is taken at the strobe's trailing edge, when it is settled
  assign take = wr_prev_q && !wr_act;
  assign rd_rise = rd_act && !rd_prev_q;
  assign idx_rise = idx && !idx_prev_q;
  // Edge history
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      // Same level as the synchroniser reset, so no false edge
      rdy_prev_q <= 1'b1;
      idx_prev_q <= 1'b1;
      hold_q <= 8'h00;
    end else begin
      wr_prev_q <= wr_act;
      rd_prev_q <= rd_act;
      rdy_prev_q <= rdy;
      idx_prev_q <= idx;
      if (wr_act) begin
        hold_q <= wdata;
      end
    end
  end

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  cmd_fields_if fields ();
  assign fields.word = hold_q;
  cmd_classifier u_classifier (
    .fields (fields.classifier)
  );
  logic is_fi, is_t1, is_t23;
  assign is_fi = fields.ctype == fdc_cmd_pkg::TYPE_IV;
  assign is_t1 = fields.ctype == fdc_cmd_pkg::TYPE_I;
  assign is_t23 = !is_fi && !is_t1;

  // ----------------------------------------
  // Acceptance
  // ----------------------------------------
  logic busy_q;
  logic accept, start, reject, fi_take;
  // The host is expected to wait for busy low R2
  // Anything but a forced interrupt is dropped while busy R25
  assign accept = take && (is_fi || !busy_q);
  assign fi_take = accept && is_fi; // R3
  // Type II/III with drive not ready never starts R23
  assign reject = accept && is_t23 && !rdy;
  assign start = accept && !is_fi && !reject;
  assign start_out = start;
  assign abort_out = fi_take && busy_q;

  // Busy: set on start, cleared by completion or termination
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (fi_take) begin
      busy_q <= 1'b0; // R3
    end else if (start) begin
      busy_q <= 1'b1; // R4
    end else if (cmd_done_in) begin
      busy_q <= 1'b0; // R5
    end
  end
  assign busy_out = busy_q;

  // ----------------------------------------
  // Held command fields
  // ----------------------------------------
  logic [7:0] w;
  assign w = hold_q;
  // Fields change only when a command starts R26
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cmd_out <= 11'h000;
      step_rate_select_out <= 2'h0;
      step_cycles_out <= '0;
      settle_cycles_out <= '0;
      verify_out <= 1'b0;
      head_load_out <= 1'b0;
      track_update_out <= 1'b0;
      data_mark_out <= fdc_cmd_pkg::MARK_NORMAL;
      side_compare_en_out <= 1'b0;
      expected_side_out <= 1'b0;
      sector_len_flag_out <= 1'b0;
      multi_record_out <= 1'b0;
    end else if (start) begin
      cmd_out <= fields.cmd;
      step_rate_select_out <= 2'h0;
      verify_out <= 1'b0;
      head_load_out <= 1'b0;
      track_update_out <= 1'b0;
      step_cycles_out <= '0;
      settle_cycles_out <= '0;
      side_compare_en_out <= 1'b0;
      expected_side_out <= 1'b0;
      sector_len_flag_out <= 1'b0;
      multi_record_out <= 1'b0;
      data_mark_out <= fdc_cmd_pkg::MARK_NORMAL;
      if (is_t1) begin
        // Rate select and interval R9
        step_rate_select_out <= w[fdc_cmd_pkg::RATE_LSB +: 2];
        // Table of intervals R24
        case (w[fdc_cmd_pkg::RATE_LSB +: 2])
          2'h0: step_cycles_out <= CW'(STEP0_CYCLES);
          2'h1: step_cycles_out <= CW'(STEP1_CYCLES);
          2'h2: step_cycles_out <= CW'(STEP2_CYCLES);
          default: step_cycles_out <= CW'(STEP3_CYCLES);
        endcase
        verify_out <= w[fdc_cmd_pkg::VERIFY_BIT]; // R10
        head_load_out <= w[fdc_cmd_pkg::HEAD_BIT]; // R11
        // Only step variants honour the update bit R12
        track_update_out <= w[fdc_cmd_pkg::UPDATE_BIT] &&
                            w[7:5] != 3'h0;
      end else begin
        // Optional settle before head engage R17
        if (w[fdc_cmd_pkg::DELAY_BIT]) begin
          settle_cycles_out <= CW'(SETTLE_CYCLES);
        end
        if (fields.ctype == fdc_cmd_pkg::TYPE_II) begin
          multi_record_out <= w[fdc_cmd_pkg::MULTI_BIT]; // R18
          if (SIDE_OUTPUT_VARIANT) begin
            sector_len_flag_out <= w[fdc_cmd_pkg::SIDE_NUM_BIT]; // R16
          end else begin
            // Side compare variant R14
            side_compare_en_out <= w[fdc_cmd_pkg::SIDE_BIT];
            expected_side_out <= w[fdc_cmd_pkg::SIDE_NUM_BIT];
          end
        end
        if (fields.cmd == fdc_cmd_pkg::CMD_WR_SEC) begin
          // Normal or deleted mark R13
          data_mark_out <= w[fdc_cmd_pkg::MARK_BIT] ?
                           fdc_cmd_pkg::MARK_DELETED :
                           fdc_cmd_pkg::MARK_NORMAL;
        end
      end
    end
  end

  // Side select follows bit 1 of type II/III on the output variant
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      side_select_output_out <= 1'b0;
    end else if (SIDE_OUTPUT_VARIANT && start && is_t23) begin
      side_select_output_out <= w[fdc_cmd_pkg::SIDE_BIT]; // R15
    end
  end

  // ----------------------------------------
  // Forced interrupt conditions
  // ----------------------------------------
  logic [2:0] fi_cond_q; // Becoming ready, losing ready, index
  logic imm_q; // Immediate interrupt latch
  // Conditions armed by each forced interrupt; zero disarms R21
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fi_cond_q <= 3'h0;
      imm_q <= 1'b0;
    end else if (fi_take) begin
      fi_cond_q <= w[2:0];
      // Only a new forced interrupt or reset removes it R20
      imm_q <= w[fdc_cmd_pkg::IMMED_BIT];
    end
  end

  // ----------------------------------------
  // Completion interrupt
  // ----------------------------------------
  logic irq_set, irq_clr, irq_q;
  logic cond_hit;
  // Ready edges and index pulses R19
  assign cond_hit = (fi_cond_q[0] && rdy && !rdy_prev_q) ||
                    (fi_cond_q[1] && !rdy && rdy_prev_q) ||
                    (fi_cond_q[2] && idx_rise);
  // A new forced interrupt drops the old immediate latch at once
  assign irq_set = (cmd_done_in && busy_q && !fi_take) || reject ||
                   cond_hit || (imm_q && !fi_take);
  // Status read or command write drops the request R22
  assign irq_clr = rd_rise || take;
  // A set in the clear cycle wins, so no event is lost
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (irq_set) begin
      irq_q <= 1'b1; // R5
    end else if (irq_clr) begin
      irq_q <= 1'b0;
    end
  end
  assign completion_irq_out = irq_q;

  // ----------------------------------------
  // Status and read data
  // ----------------------------------------
  logic [5:0] err_q; // Error flags of the last command
  logic [7:0] status;
  // Errors captured at completion, cleared on a new start R6
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= fdc_cmd_pkg::STATUS_RESET[6:1];
    end else if (start) begin
      err_q <= 6'h00;
    end else if (cmd_done_in && busy_q) begin
      err_q <= err_flags_in; // R6
    end
  end
  assign status = {!rdy, err_q, busy_q};
  // Read data registered from the status word
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= fdc_cmd_pkg::STATUS_RESET;
      data_oe_out <= 1'b0;
    end else begin
      data_oe_out <= rd_act;
      if (rd_act) begin
        data_out <= status;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);
  a_busy_on_start: assert property ( // R4
    start || busy_q && !cmd_done_in && !fi_take |=> busy_q)
    else $error("busy not held while running");
  a_done_clears: assert property ( // R5
    cmd_done_in && busy_q && !take |=> !busy_q && irq_q)
    else $error("completion did not clear busy and raise irq");
  a_fi_busy: assert property ( // R3
    take && is_fi && busy_q |-> abort_out ##1 !busy_q)
    else $error("forced interrupt ignored while busy");
  a_busy_ignore: assert property ( // R25
    take && !is_fi && busy_q |-> !start_out ##1 $stable(cmd_out))
    else $error("command taken while busy");
  a_not_ready: assert property ( // R23
    take && !busy_q && is_t23 && !rdy |=> irq_q && !busy_q)
    else $error("not-ready command executed");
  a_fi_zero: assert property ( // R21
    take && is_fi && w[3:0] == 4'h0 && !cond_hit |=> !irq_q)
    else $error("zero-condition forced interrupt raised irq");
  a_step_rate: assert property ( // R24
    start && is_t1 && w[1:0] == 2'h3 |=>
      step_cycles_out == CW'(STEP3_CYCLES))
    else $error("wrong step interval");
  a_irq_read: assert property (rd_rise && !irq_set |=> !irq_q) // R22
    else $error("status read did not clear irq");
  a_imm_sticky: assert property (imm_q && !fi_take |=> irq_q && imm_q) // R20
    else $error("immediate interrupt dropped");
  a_mark_sel: assert property ( // R13
    start && fields.cmd == fdc_cmd_pkg::CMD_WR_SEC |=>
      data_mark_out == ($past(w[0]) ? 8'hF8 : 8'hFB))
    else $error("wrong data mark");
  c_type1: cover property (start && is_t1 ##[1:50] cmd_done_in);
  c_fi_busy: cover property (busy_q && fi_take);
  c_reject: cover property (reject);
  c_irq_read: cover property (irq_q ##1 rd_rise);
endmodule
`default_nettype wire

// [tb/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Host processor: writes command words, reads status
// ----
module host_model (
  // Clock and decoder answers
  input wire logic clk_in,
  input wire logic busy_in,
  input wire logic [7:0] data_in,
  input wire logic data_oe_in,
  // Strobes and bus toward the decoder
  output logic cs_n_out,
  output logic we_n_out,
  output logic re_n_out,
  output logic [1:0] addr_out,
  output logic [7:0] data_out
);
  // Idle bus at time zero
  initial begin
    cs_n_out = 1'b1;
    we_n_out = 1'b1;
    re_n_out = 1'b1;
    addr_out = 2'h0;
    data_out = 8'h5A;
  end
  // Command write; rude skips the idle wait on purpose
  task automatic write_cmd(input logic [7:0] w, input bit rude);
    int n;
    n = 0;
    // Polite host waits for busy clear unless forcing
    while (!rude && w[7:4] != 4'hD && busy_in !== 1'b0 && n < 5000) begin
      @(posedge clk_in);
      n++;
    end
    @(posedge clk_in);
    #1;
    cs_n_out = 1'b0;
    we_n_out = 1'b0;
    addr_out = 2'h0;
    data_out = w;
    // Synchroniser needs at least three cycles low
    repeat (4) @(posedge clk_in);
    #1;
    cs_n_out = 1'b1;
    we_n_out = 1'b1;
    repeat (2) @(posedge clk_in);
    // Hold time over: a stale copy must not pass for data
    #1 data_out = ~w;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  // Status read, taken once the decoder drives the bus
  task automatic read_status(output logic [7:0] v);
    int n;
    @(posedge clk_in);
    #1;
    cs_n_out = 1'b0;
    re_n_out = 1'b0;
    addr_out = 2'h0;
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (data_oe_in !== 1'b1 && n < 20);
    v = data_in;
    repeat (2) @(posedge clk_in);
    #1;
    cs_n_out = 1'b1;
    re_n_out = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// [tb/floppy_command_decoder_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module floppy_command_decoder_tb;
  // ----
  // Signals
  // ----
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ready = 1'b1;
  logic index = 1'b0;
  logic done = 1'b0;
  logic [5:0] err = 6'h00;
  logic cs_n, we_n, re_n, oe, busy, irq, start, abort, side;
  logic verify, head, upd, es, sc, slen, multi;
  logic [1:0] addr, rate;
  logic [7:0] wdata, rdata, st, mark, w;
  logic [10:0] cmd;
  logic [23:0] step_c, settle_c;
  logic [7:0] base [10] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h60, 8'h80,
    8'hA0, 8'hC0, 8'hE0, 8'hF0};
  logic [7:0] rej [3] = '{8'h80, 8'hE4, 8'h10};
  int n_errors = 0;
  int total_checks = 0;
  int n_start = 0;
  int n_abort = 0;
  int na;
  // ----
  // Design and host
  // ----
  floppy_command_decoder #(.STEP0_CYCLES(3), .STEP1_CYCLES(6),
    .STEP2_CYCLES(10), .STEP3_CYCLES(15), .SETTLE_CYCLES(15))
    floppy_command_decoder_inst (
    .ref_clk_in(clk), .resetn_in(resetn), .cs_n_in(cs_n),
    .we_n_in(we_n), .re_n_in(re_n), .addr_in(addr), .data_in(wdata),
    .data_out(rdata), .data_oe_out(oe), .drive_ready_in(ready),
    .index_in(index), .side_select_output_out(side),
    .completion_irq_out(irq), .cmd_done_in(done), .err_flags_in(err),
    .start_out(start), .abort_out(abort), .busy_out(busy),
    .cmd_out(cmd), .step_rate_select_out(rate), .step_cycles_out(step_c),
    .settle_cycles_out(settle_c), .verify_out(verify),
    .head_load_out(head), .track_update_out(upd), .data_mark_out(mark),
    .side_compare_en_out(sc), .expected_side_out(es),
    .sector_len_flag_out(slen), .multi_record_out(multi));
  host_model host_model_inst (.clk_in(clk), .busy_in(busy),
    .data_in(rdata), .data_oe_in(oe), .cs_n_out(cs_n), .we_n_out(we_n),
    .re_n_out(re_n), .addr_out(addr), .data_out(wdata));
  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end
  // Pulses are counted mid-cycle, clear of the edge
  always @(negedge clk) begin
    if (start === 1'b1) n_start++;
    if (abort === 1'b1) n_abort++;
  end
  // ----
  // Expectations and checking
  // ----
  function automatic logic [10:0] exp_cmd(input logic [7:0] v);
    casez (v[7:4])
      4'b0000: return 11'h001;
      4'b0001: return 11'h002;
      4'b001?: return 11'h004;
      4'b010?: return 11'h008;
      4'b011?: return 11'h010;
      4'b100?: return 11'h020;
      4'b101?: return 11'h040;
      4'b1100: return 11'h080;
      4'b1110: return 11'h100;
      4'b1111: return 11'h200;
      default: return 11'h400;
    endcase
  endfunction
  // Irrelevant fields read zero, mark defaults to normal
  function automatic logic [16:0] exp_fields(input logic [7:0] v);
    logic [7:0] m;
    m = (v[7:5] == 3'h5 && v[0]) ? 8'hF8 : 8'hFB;
    if (!v[7]) return {v[1:0], v[2], v[3], v[4] & |v[6:5], m, 4'h0};
    return {5'h00, m, 2'h0, ~v[6] & v[3], ~v[6] & v[4]};
  endfunction
  function automatic int step_of(input logic [1:0] r);
    return r == 2'h0 ? 3 : r == 2'h1 ? 6 : r == 2'h2 ? 10 : 15;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----
  // Engine and drive stimulus
  // ----
  task automatic pulse_done(input logic [5:0] e);
    err = e;
    done = 1'b1;
    @(posedge clk);
    #1;
    done = 1'b0;
    err = ~e;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic edge_irq(input logic rdy, input logic idx, input logic x);
    ready = rdy;
    index = idx;
    repeat (3) @(posedge clk);
    #1 index = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(32'(irq), 32'(x));
    host_model_inst.read_status(st);
  endtask
  // One full command: decode, busy, completion, status
  task automatic run_cmd(input logic [7:0] v, input bit rude);
    int n0;
    logic [5:0] e;
    n0 = n_start;
    e = 6'($urandom);
    host_model_inst.write_cmd(v, 1'b0);
    check(32'(n_start - n0), 32'h1);
    check(32'(cmd), 32'(exp_cmd(v)));
    check(32'({rate, verify, head, upd, mark, sc, es, slen, multi}),
      32'(exp_fields(v)));
    check(32'(step_c), 32'(v[7] ? 0 : step_of(v[1:0])));
    if (v[7]) begin
      check(32'(settle_c), v[2] ? 32'hF : 32'h0);
      check(32'(side), 32'(v[1]));
    end
    // A second word while busy must leave the first alone
    if (rude) begin
      host_model_inst.write_cmd(v[7] ? 8'h00 : 8'hF0, 1'b1);
      check(32'(n_start - n0), 32'h1);
      check(32'(cmd), 32'(exp_cmd(v)));
    end
    repeat ($urandom_range(1, 20)) @(posedge clk);
    #1;
    check(32'(busy), 32'h1);
    pulse_done(e);
    check(32'({busy, irq}), 32'h1);
    host_model_inst.read_status(st);
    check(32'(st), 32'({1'b0, e, 1'b0}));
    check(32'(irq), 32'h0);
  endtask
  // ----
  // Tests
  // ----
  initial begin
    void'($urandom(32'hCA2D2296));
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (5) @(posedge clk);
    // Every opcode but forced interrupt, every rate code, random flags
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 10; i++) begin
        w = base[i] | (8'($urandom) & (i inside {[2:6]} ? 8'h1F : 8'h0F));
        if (!w[7]) w[1:0] = 2'(k);
        run_cmd(w, i == k);
      end
    end
    $display("test decode done");
    host_model_inst.write_cmd(8'h03, 1'b0);
    na = n_abort;
    host_model_inst.write_cmd(8'hD0, 1'b1);
    check(32'(n_abort - na), 32'h1);
    check(32'({busy, irq}), 32'h0);
    $display("test abort done");
    host_model_inst.write_cmd(8'hD8, 1'b0);
    check(32'(irq), 32'h1);
    host_model_inst.read_status(st);
    check(32'(irq), 32'h1);
    host_model_inst.write_cmd(8'hD0, 1'b0);
    check(32'(irq), 32'h0);
    $display("test immediate done");
    host_model_inst.write_cmd(8'hD3, 1'b0);
    edge_irq(1'b0, 1'b0, 1'b1);
    edge_irq(1'b1, 1'b0, 1'b1);
    host_model_inst.write_cmd(8'hD4, 1'b0);
    edge_irq(1'b1, 1'b1, 1'b1);
    host_model_inst.write_cmd(8'hD0, 1'b0);
    edge_irq(1'b1, 1'b1, 1'b0);
    edge_irq(1'b0, 1'b0, 1'b0);
    $display("test conditions done");
    // Drive not ready: only the seek command runs
    foreach (rej[j]) begin
      na = n_start;
      host_model_inst.write_cmd(rej[j], 1'b0);
      check(32'(n_start - na), 32'(!rej[j][7]));
      check(32'({busy, irq}), rej[j][7] ? 32'h1 : 32'h2);
    end
    pulse_done(6'h00);
    ready = 1'b1;
    $display("test not ready done");
    tally_and_finish();
  end
  // Run needs about 1700 cycles; allow ample margin
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
`default_nettype wire
